/* src/bcim_pkg.sv */
`default_nettype none
package bcim_pkg;

    // ****************************************************************
    // Clock and time base
    // ****************************************************************
    localparam int unsigned CLK_HZ          = 250_000_000;
    localparam int unsigned TICK_US         = 1000;
    localparam int unsigned TICK_CYC        = CLK_HZ / 1_000_000 * TICK_US;
    localparam int unsigned MS_PER_MIN      = 60_000;
    localparam int unsigned QUIET_MIN       = 5;
    localparam int unsigned WARN_MIN        = 10;
    localparam int unsigned ERR_MIN         = QUIET_MIN + WARN_MIN;
    localparam int unsigned END_WARN_MIN    = 15;
    localparam int unsigned QUIET_MS        = QUIET_MIN * MS_PER_MIN;
    localparam int unsigned ERR_MS          = ERR_MIN * MS_PER_MIN;
    localparam int unsigned END_WARN_MS     = END_WARN_MIN * MS_PER_MIN;

    // Torque scale: a check starts only if the test torque is at least 13/10 of the safety load.
    localparam int unsigned TORQUE_NUM      = 13;
    localparam int unsigned TORQUE_DEN      = 10;

    // Direction configuration encoding.
    localparam logic [1:0]  DIR_POS         = 2'h1;
    localparam logic [1:0]  DIR_NEG         = 2'h2;

    // Interrupt status bit positions.
    localparam int unsigned IRQ_N           = 6;
    localparam int unsigned EV_DONE         = 0;
    localparam int unsigned EV_REL_ERR      = 1;
    localparam int unsigned EV_MOT_ERR      = 2;
    localparam int unsigned EV_RED_ERR      = 3;
    localparam int unsigned EV_EXCEED       = 4;
    localparam int unsigned EV_MISSING      = 5;

    // Register map, byte offsets.
    localparam logic [7:0]  REG_CTRL        = 8'h00;
    localparam logic [7:0]  REG_INTERVAL    = 8'h04;
    localparam logic [7:0]  REG_TRAVEL      = 8'h08;
    localparam logic [7:0]  REG_INJECT      = 8'h0c;
    localparam logic [7:0]  REG_NOMLOAD     = 8'h10;
    localparam logic [7:0]  REG_SAFELOAD    = 8'h14;
    localparam logic [7:0]  REG_STATUS      = 8'h18;
    localparam logic [7:0]  REG_IRQ_STAT    = 8'h1c;
    localparam logic [7:0]  REG_IRQ_EN      = 8'h20;
    localparam logic [7:0]  REG_IRQ_CLR     = 8'h24;
    localparam logic [7:0]  REG_REMAIN      = 8'h28;
    localparam logic [7:0]  REG_HOURS       = 8'h2c;

    // Control register bits.
    localparam int unsigned CTRL_START      = 0;
    localparam int unsigned CTRL_CLR_ERR    = 1;
    localparam int unsigned CTRL_DIR_LO     = 4;

    // Check sequencer states, Gray along the usual path except BCIM_RED to BCIM_FLIP and BCIM_DONE back to BCIM_IDLE.
    typedef enum logic [2:0] {
        BCIM_IDLE    = 3'b000,
        BCIM_RELEASE = 3'b001,
        BCIM_MOTOR   = 3'b011,
        BCIM_RED     = 3'b010,
        BCIM_FLIP    = 3'b111,
        BCIM_DONE    = 3'b110
    } bcim_state_t;

endpackage
`default_nettype wire

/* src/bcim_channel.sv */
`timescale 1ns/100ps
`default_nettype none
// ****************************************************************
// One validity timing channel
// ****************************************************************
module bcim_channel
    import bcim_pkg::*;
(
    input  wire logic        clk_in,
    input  wire logic        rst_in,
    input  wire logic        tick_in,
    input  wire logic        pass_in,
    input  wire logic [31:0] interval_in,
    output logic             valid_out,
    output logic [31:0]      remain_out
);

    // Remaining time counts in milliseconds of operating time.
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            valid_out  <= 1'b0;
            remain_out <= 32'h0;
        end else if (pass_in) begin
            valid_out  <= (interval_in != 32'h0);
            remain_out <= interval_in;
        end else if (tick_in && valid_out) begin
            // Runs on every tick, regulated or not.
            remain_out <= remain_out - 32'h1;
            if (remain_out == 32'h1) begin
                valid_out <= 1'b0;
            end
        end
    end

endmodule
`default_nettype wire

/* src/bcim_top.sv */
`timescale 1ns/100ps
`default_nettype none
module bcim_top
    import bcim_pkg::*;
(
    input  wire logic        MCLK_IN,
    input  wire logic        SYS_RST_IN,
    input  wire logic [7:0]  ADDR_IN,
    input  wire logic [31:0] WDATA_IN,
    input  wire logic        WR_IN,
    input  wire logic        RD_IN,
    input  wire logic        DRIVE_ENABLE_IN,
    input  wire logic        SPECIAL_MODE_IN,
    input  wire logic [31:0] AXIS_POS_IN,
    input  wire logic [31:0] TORQUE_ACT_IN,
    output logic [31:0]      RDATA_OUT,
    output logic             MOTOR_BRAKE_RELEASE_OUT,
    output logic             RED_BRAKE_RELEASE_OUT,
    output logic [31:0]      TORQUE_CMD_OUT,
    output logic             TORQUE_NEG_OUT,
    output logic             MOVE_REQ_OUT,
    output logic             BUSY_OUT,
    output logic             MOTOR_VALID_OUT,
    output logic             RED_VALID_OUT,
    output logic             HOLD_USABLE_OUT,
    output logic             PREWARNING_OUT,
    output logic             EXCEEDED_ERROR_OUT,
    output logic             MISSING_ERROR_OUT,
    output logic             IRQ_OUT
);

    // ****************************************************************
    // Registers and time base
    // ****************************************************************
    logic [31:0]       interval;
    logic [31:0]       travel;
    logic [31:0]       inject;
    logic [31:0]       nomload;
    logic [31:0]       safeload;
    logic [1:0]        dir_cfg;
    logic [IRQ_N-1:0]  irq_stat;
    logic [IRQ_N-1:0]  irq_en;
    logic [31:0]       tick_cnt;
    logic              tick;
    logic [31:0]       hours_ms;
    logic [31:0]       en_ms;
    logic              exceeded;
    logic              missing;
    logic              motor_valid;
    logic              red_valid;
    logic [31:0]       remain_a;
    logic [31:0]       remain_b;
    logic              usable;

    bcim_state_t       state;
    bcim_state_t       next_state;
    logic              neg_dir;
    logic [31:0]       start_pos;
    logic [31:0]       phase_cnt;
    logic              pass;
    logic [IRQ_N-1:0]  events;

    // Decode of bus strobes.
    wire wr_ctrl  = WR_IN && (ADDR_IN == REG_CTRL);
    wire wr_clr   = WR_IN && (ADDR_IN == REG_IRQ_CLR);
    wire start_rq = wr_ctrl && WDATA_IN[CTRL_START];
    wire clear_rq = wr_ctrl && WDATA_IN[CTRL_CLR_ERR];
    wire normal_en = DRIVE_ENABLE_IN && !SPECIAL_MODE_IN;
    wire accept   = start_rq && normal_en && (state == BCIM_IDLE);
    wire both_valid = motor_valid && red_valid;

    // Millisecond tick from the clock; it is the operating-hours base.
    always_ff @(posedge MCLK_IN or posedge SYS_RST_IN) begin
        if (SYS_RST_IN) begin
            tick_cnt <= 32'h0;
            tick     <= 1'b0;
            hours_ms <= 32'h0;
        end else begin
            tick     <= (tick_cnt == TICK_CYC - 1);
            tick_cnt <= (tick_cnt == TICK_CYC - 1) ? 32'h0 : tick_cnt + 32'h1;
            hours_ms <= hours_ms + {31'h0, tick};
        end
    end

    // ****************************************************************
    // Two independent validity channels
    // ****************************************************************
    // Each brake status keeps its own counter so one slip cannot hide the other.
    bcim_channel u_motor_ch (
        .clk_in      (MCLK_IN),
        .rst_in      (SYS_RST_IN),
        .tick_in     (tick),
        .pass_in     (pass),
        .interval_in (interval),
        .valid_out   (motor_valid),
        .remain_out  (remain_a)
    );

    bcim_channel u_red_ch (
        .clk_in      (MCLK_IN),
        .rst_in      (SYS_RST_IN),
        .tick_in     (tick),
        .pass_in     (pass),
        .interval_in (interval),
        .valid_out   (red_valid),
        .remain_out  (remain_b)
    );

    // ****************************************************************
    // Missing and overdue supervision
    // ****************************************************************
    // Time under drive enable while status is invalid in normal operation.
    always_ff @(posedge MCLK_IN or posedge SYS_RST_IN) begin
        if (SYS_RST_IN) begin
            en_ms <= 32'h0;
        end else if (both_valid || !normal_en || clear_rq || pass) begin
            en_ms <= 32'h0;
        end else if (tick && en_ms < ERR_MS) begin
            en_ms <= en_ms + 32'h1;
        end
    end

    wire warn_invalid = !both_valid && normal_en && (en_ms >= QUIET_MS) && (en_ms < ERR_MS);
    wire over_invalid = !both_valid && normal_en && (en_ms >= ERR_MS);
    wire warn_valid   = both_valid && DRIVE_ENABLE_IN && (remain_a <= END_WARN_MS);
    wire expire       = tick && motor_valid && (remain_a == 32'h1);
    wire miss_now     = !both_valid && SPECIAL_MODE_IN;

    // Exceeded error is sticky until cleared; a new cause wins over the clear.
    always_ff @(posedge MCLK_IN or posedge SYS_RST_IN) begin
        if (SYS_RST_IN) begin
            exceeded <= 1'b0;
        end else if (over_invalid || (expire && DRIVE_ENABLE_IN)) begin
            exceeded <= 1'b1;
        end else if (clear_rq || pass) begin
            exceeded <= 1'b0;
        end
    end

    always_ff @(posedge MCLK_IN or posedge SYS_RST_IN) begin
        if (SYS_RST_IN) begin
            missing <= 1'b0;
        end else begin
            missing <= miss_now;
        end
    end

    // Usable only after a pass since power-up and while status holds.
    always_ff @(posedge MCLK_IN or posedge SYS_RST_IN) begin
        if (SYS_RST_IN) begin
            usable <= 1'b0;
        end else begin
            usable <= both_valid && !pass;
        end
    end

    // ****************************************************************
    // Check sequencer
    // ****************************************************************
    wire [31:0] moved     = (AXIS_POS_IN >= start_pos) ? AXIS_POS_IN - start_pos : start_pos - AXIS_POS_IN;
    wire        too_far   = (moved > travel);
    wire        reached   = (moved >= travel);
    wire        time_up   = (phase_cnt >= inject);
    wire [63:0] scaled    = ({32'h0, safeload} * TORQUE_NUM) / TORQUE_DEN;
    wire [31:0] test_trq  = nomload;
    wire        trq_ok    = ({32'h0, test_trq} >= scaled);
    wire        trq_hit   = (TORQUE_ACT_IN >= safeload);
    // The start word carries the direction; dir_cfg only takes it at that same edge.
    wire        first_neg = (WDATA_IN[CTRL_DIR_LO +: 2] == DIR_NEG);
    wire        do_second = (dir_cfg != DIR_POS) && (dir_cfg != DIR_NEG) && !neg_dir;
    wire        rel_fail  = (state == BCIM_RELEASE) && time_up && !reached;
    wire        mot_fail  = (state == BCIM_MOTOR) && (too_far || (time_up && !trq_hit));
    wire        red_fail  = (state == BCIM_RED) && (too_far || (time_up && !trq_hit));

    // Next state selection.
    always_comb begin
        next_state = state;
        case (state)
            BCIM_IDLE: begin
                if (accept) begin
                    next_state = trq_ok ? BCIM_RELEASE : BCIM_IDLE;
                end
            end
            BCIM_RELEASE: begin
                if (rel_fail) begin
                    next_state = BCIM_IDLE;
                end else if (reached) begin
                    next_state = BCIM_MOTOR;
                end
            end
            BCIM_MOTOR: begin
                if (mot_fail) begin
                    next_state = BCIM_IDLE;
                end else if (time_up) begin
                    next_state = BCIM_RED;
                end
            end
            BCIM_RED: begin
                if (red_fail) begin
                    next_state = BCIM_IDLE;
                end else if (time_up) begin
                    next_state = do_second ? BCIM_FLIP : BCIM_DONE;
                end
            end
            BCIM_FLIP:  next_state = BCIM_MOTOR;
            BCIM_DONE:  next_state = BCIM_IDLE;
            default:    next_state = BCIM_IDLE;
        endcase
        if (state != BCIM_IDLE && !normal_en) begin
            next_state = BCIM_IDLE;
        end
    end

    // State, phase timer and start position.
    always_ff @(posedge MCLK_IN or posedge SYS_RST_IN) begin
        if (SYS_RST_IN) begin
            state     <= BCIM_IDLE;
            phase_cnt <= 32'h0;
            start_pos <= 32'h0;
            neg_dir   <= 1'b0;
            pass      <= 1'b0;
        end else begin
            state     <= next_state;
            pass      <= (state == BCIM_DONE);
            phase_cnt <= (next_state != state) ? 32'h0 : phase_cnt + 32'h1;
            if (next_state != state) begin
                start_pos <= AXIS_POS_IN;
            end
            if (accept && trq_ok) begin
                neg_dir <= first_neg;
            end else if (state == BCIM_FLIP) begin
                neg_dir <= 1'b1;
            end else if (state == BCIM_IDLE) begin
                neg_dir <= 1'b0;
            end
        end
    end

    // Sticky events: hardware set wins over a software clear.
    assign events[EV_DONE]    = (state == BCIM_DONE);
    assign events[EV_REL_ERR] = rel_fail;
    assign events[EV_MOT_ERR] = mot_fail;
    assign events[EV_RED_ERR] = red_fail;
    assign events[EV_EXCEED]  = over_invalid || expire;
    assign events[EV_MISSING] = miss_now;

    always_ff @(posedge MCLK_IN or posedge SYS_RST_IN) begin
        if (SYS_RST_IN) begin
            irq_stat <= '0;
        end else begin
            irq_stat <= (irq_stat & ~(wr_clr ? WDATA_IN[IRQ_N-1:0] : '0)) | events;
        end
    end

    // ****************************************************************
    // Register writes and reads
    // ****************************************************************
    always_ff @(posedge MCLK_IN or posedge SYS_RST_IN) begin
        if (SYS_RST_IN) begin
            interval <= 32'h0;
            travel   <= 32'h0;
            inject   <= 32'h0;
            nomload  <= 32'h0;
            safeload <= 32'h0;
            dir_cfg  <= 2'h3;
            irq_en   <= '0;
        end else if (WR_IN) begin
            case (ADDR_IN)
                REG_CTRL:     dir_cfg  <= WDATA_IN[CTRL_DIR_LO +: 2];
                REG_INTERVAL: interval <= WDATA_IN;
                REG_TRAVEL:   travel   <= WDATA_IN;
                REG_INJECT:   inject   <= WDATA_IN;
                REG_NOMLOAD:  nomload  <= WDATA_IN;
                REG_SAFELOAD: safeload <= WDATA_IN;
                REG_IRQ_EN:   irq_en   <= WDATA_IN[IRQ_N-1:0];
                default:      irq_en   <= irq_en;
            endcase
        end
    end

    wire [31:0] status_word = {23'h0, state, usable, missing, exceeded, PREWARNING_OUT, red_valid, motor_valid};
    wire [31:0] rd_mux =
        (ADDR_IN == REG_CTRL)     ? {26'h0, dir_cfg, 4'h0} :
        (ADDR_IN == REG_INTERVAL) ? interval :
        (ADDR_IN == REG_TRAVEL)   ? travel :
        (ADDR_IN == REG_INJECT)   ? inject :
        (ADDR_IN == REG_NOMLOAD)  ? nomload :
        (ADDR_IN == REG_SAFELOAD) ? safeload :
        (ADDR_IN == REG_STATUS)   ? status_word :
        (ADDR_IN == REG_IRQ_STAT) ? {26'h0, irq_stat} :
        (ADDR_IN == REG_IRQ_EN)   ? {26'h0, irq_en} :
        (ADDR_IN == REG_REMAIN)   ? remain_a :
        (ADDR_IN == REG_HOURS)    ? hours_ms : 32'h0;

    // Registered outputs; all track internal state one cycle later.
    always_ff @(posedge MCLK_IN or posedge SYS_RST_IN) begin
        if (SYS_RST_IN) begin
            RDATA_OUT               <= 32'h0;
            MOTOR_BRAKE_RELEASE_OUT <= 1'b0;
            RED_BRAKE_RELEASE_OUT   <= 1'b0;
            TORQUE_CMD_OUT          <= 32'h0;
            TORQUE_NEG_OUT          <= 1'b0;
            MOVE_REQ_OUT            <= 1'b0;
            BUSY_OUT                <= 1'b0;
            MOTOR_VALID_OUT         <= 1'b0;
            RED_VALID_OUT           <= 1'b0;
            HOLD_USABLE_OUT         <= 1'b0;
            PREWARNING_OUT          <= 1'b0;
            EXCEEDED_ERROR_OUT      <= 1'b0;
            MISSING_ERROR_OUT       <= 1'b0;
            IRQ_OUT                 <= 1'b0;
        end else begin
            RDATA_OUT               <= RD_IN ? rd_mux : 32'h0;
            MOTOR_BRAKE_RELEASE_OUT <= (state == BCIM_RELEASE) || (state == BCIM_RED);
            RED_BRAKE_RELEASE_OUT   <= (state == BCIM_RELEASE) || (state == BCIM_MOTOR);
            TORQUE_CMD_OUT          <= ((state == BCIM_MOTOR) || (state == BCIM_RED)) ? test_trq : 32'h0;
            TORQUE_NEG_OUT          <= neg_dir;
            MOVE_REQ_OUT            <= (state == BCIM_RELEASE);
            BUSY_OUT                <= (state != BCIM_IDLE);
            MOTOR_VALID_OUT         <= motor_valid;
            RED_VALID_OUT           <= red_valid;
            HOLD_USABLE_OUT         <= usable;
            PREWARNING_OUT          <= (warn_invalid || warn_valid) && !pass;
            EXCEEDED_ERROR_OUT      <= exceeded;
            MISSING_ERROR_OUT       <= missing;
            IRQ_OUT                 <= |(irq_stat & irq_en);
        end
    end

endmodule
`default_nettype wire

/* dv/bcim_chk.sv */
`timescale 1ns/100ps
`default_nettype none
// ****************************************************************
// Port checker for the brake check monitor
// ****************************************************************
module bcim_chk (
    input wire logic        MCLK_IN,
    input wire logic        SYS_RST_IN,
    input wire logic        RD_IN,
    input wire logic        DRIVE_ENABLE_IN,
    input wire logic        SPECIAL_MODE_IN,
    input wire logic [31:0] RDATA_OUT,
    input wire logic        MOTOR_BRAKE_RELEASE_OUT,
    input wire logic        RED_BRAKE_RELEASE_OUT,
    input wire logic [31:0] TORQUE_CMD_OUT,
    input wire logic        TORQUE_NEG_OUT,
    input wire logic        MOVE_REQ_OUT,
    input wire logic        BUSY_OUT,
    input wire logic        MOTOR_VALID_OUT,
    input wire logic        RED_VALID_OUT,
    input wire logic        HOLD_USABLE_OUT,
    input wire logic        MISSING_ERROR_OUT
);
    // One clock domain, so clock and reset are stated once for all properties.
    default clocking @(posedge MCLK_IN); endclocking
    default disable iff (SYS_RST_IN);
    wire torque_on = TORQUE_CMD_OUT != 32'h0;
    wire invalid   = !MOTOR_VALID_OUT && !RED_VALID_OUT;

    chk_reset_invalid: assert property ($fell(SYS_RST_IN) |-> invalid)
        else $error("Brake state valid right after reset.");
    chk_missing_special: assert property ((SPECIAL_MODE_IN && invalid) [*4] |-> MISSING_ERROR_OUT)
        else $error("Missing check error absent in special mode.");
    chk_start_gate: assert property ($rose(BUSY_OUT)
        |-> $past(DRIVE_ENABLE_IN, 2) && !$past(SPECIAL_MODE_IN, 2))
        else $error("Check started outside normal enabled operation.");
    chk_release_move: assert property (MOVE_REQ_OUT |-> MOTOR_BRAKE_RELEASE_OUT && RED_BRAKE_RELEASE_OUT)
        else $error("Axis moved with a brake applied.");
    chk_torque_one_brake: assert property (torque_on |-> BUSY_OUT && (MOTOR_BRAKE_RELEASE_OUT ^ RED_BRAKE_RELEASE_OUT))
        else $error("Test torque without exactly one brake applied.");
    chk_neg_in_check: assert property ($rose(TORQUE_NEG_OUT) |-> BUSY_OUT)
        else $error("Negative direction outside a check.");
    chk_valid_after_check: assert property ($rose(MOTOR_VALID_OUT) || $rose(RED_VALID_OUT)
        |-> $past(BUSY_OUT) || $past(BUSY_OUT, 2) || $past(BUSY_OUT, 3))
        else $error("Brake state became valid without a check.");
    chk_usable_valid: assert property (HOLD_USABLE_OUT |-> MOTOR_VALID_OUT || $past(MOTOR_VALID_OUT))
        else $error("Holding function usable without a valid check.");
    chk_rdata_idle: assert property (!$past(RD_IN) |-> RDATA_OUT == 32'h0)
        else $error("Read data outside the read answer cycle.");

    // The main scenarios: a passed check, a negative round, the missing error.
    cover property ($rose(HOLD_USABLE_OUT));
    cover property (torque_on && TORQUE_NEG_OUT);
    cover property ($rose(MISSING_ERROR_OUT));
endmodule

bind bcim_top bcim_chk chk_u (.MCLK_IN(MCLK_IN), .SYS_RST_IN(SYS_RST_IN), .RD_IN(RD_IN),
    .DRIVE_ENABLE_IN(DRIVE_ENABLE_IN), .SPECIAL_MODE_IN(SPECIAL_MODE_IN), .RDATA_OUT(RDATA_OUT),
    .MOTOR_BRAKE_RELEASE_OUT(MOTOR_BRAKE_RELEASE_OUT), .RED_BRAKE_RELEASE_OUT(RED_BRAKE_RELEASE_OUT),
    .TORQUE_CMD_OUT(TORQUE_CMD_OUT), .TORQUE_NEG_OUT(TORQUE_NEG_OUT), .MOVE_REQ_OUT(MOVE_REQ_OUT),
    .BUSY_OUT(BUSY_OUT), .MOTOR_VALID_OUT(MOTOR_VALID_OUT), .RED_VALID_OUT(RED_VALID_OUT),
    .HOLD_USABLE_OUT(HOLD_USABLE_OUT), .MISSING_ERROR_OUT(MISSING_ERROR_OUT));
`default_nettype wire

/* dv/bcim_axis_model.sv */
`timescale 1ns/100ps
`default_nettype none
// ****************************************************************
// Axis with two holding brakes
// ****************************************************************
module bcim_axis_model #(
    parameter logic [31:0] TRAVEL = 32'h8
) (
    input  wire logic        clk_in,
    input  wire logic        rst_in,
    input  wire logic [1:0]  fault_in,
    input  wire logic        move_in,
    input  wire logic        mot_rel_in,
    input  wire logic        red_rel_in,
    input  wire logic [31:0] torque_cmd_in,
    input  wire logic        neg_in,
    output logic      [31:0] pos_out,
    output logic      [31:0] torque_out
);
    logic [31:0] moved;
    // The drive reaches the commanded test torque at once.
    assign torque_out = torque_cmd_in;
    // Fault 1 jams the axis, 2 and 3 let one brake slip; a move stops at the travel range.
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            pos_out <= 32'h1000;
            moved   <= 32'h0;
        end else if (move_in && fault_in != 2'h1 && moved < TRAVEL) begin
            pos_out <= pos_out + 32'h1;
            moved   <= moved + 32'h1;
        end else if (torque_cmd_in != 32'h0 && ((fault_in == 2'h2 && !mot_rel_in) ||
                     (fault_in == 2'h3 && !red_rel_in))) begin
            pos_out <= neg_in ? pos_out - 32'h1 : pos_out + 32'h1;
        end else if (!move_in) begin
            moved   <= 32'h0;
        end
    end
endmodule
`default_nettype wire

/* dv/test_brake_check_interval_monitor.sv */
`timescale 1ns/100ps
`default_nettype none
module test_brake_check_interval_monitor
    import bcim_pkg::*;
;
    logic        mclk = 1'b0;
    logic        rst = 1'b1;
    logic [7:0]  addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic        wr = 1'b0, rd = 1'b0, en = 1'b0, spec = 1'b0;
    logic [1:0]  fault = 2'h0;
    logic [31:0] pos, tact, rdata, tcmd, rv;
    logic        mrel, rrel, neg, move, busy, mval, rval, usable, warn, exc, miss, irq;
    logic        s_rel, s_mot, s_red, s_pos, s_neg;
    int          bad_count = 0, num_checks = 0, cycles = 0;

    bcim_top dut_u (
        .MCLK_IN(mclk), .SYS_RST_IN(rst), .ADDR_IN(addr), .WDATA_IN(wdata), .WR_IN(wr), .RD_IN(rd),
        .DRIVE_ENABLE_IN(en), .SPECIAL_MODE_IN(spec), .AXIS_POS_IN(pos), .TORQUE_ACT_IN(tact),
        .RDATA_OUT(rdata), .MOTOR_BRAKE_RELEASE_OUT(mrel), .RED_BRAKE_RELEASE_OUT(rrel),
        .TORQUE_CMD_OUT(tcmd), .TORQUE_NEG_OUT(neg), .MOVE_REQ_OUT(move), .BUSY_OUT(busy),
        .MOTOR_VALID_OUT(mval), .RED_VALID_OUT(rval), .HOLD_USABLE_OUT(usable), .PREWARNING_OUT(warn),
        .EXCEEDED_ERROR_OUT(exc), .MISSING_ERROR_OUT(miss), .IRQ_OUT(irq));
    bcim_axis_model #(.TRAVEL(32'h8)) axis_u (
        .clk_in(mclk), .rst_in(rst), .fault_in(fault), .move_in(move), .mot_rel_in(mrel),
        .red_rel_in(rrel), .torque_cmd_in(tcmd), .neg_in(neg), .pos_out(pos), .torque_out(tact));

    // ****************************************************************
    // Clock, hang guard and shared tasks
    // ****************************************************************
    always #2 mclk = ~mclk;
    // The whole run needs well under a thousand cycles, so this ceiling only trips on a hang.
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            results();
        end
    end
    task automatic results();
        if (bad_count == 0 && num_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge mclk);
        wr    <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe, so they are taken there.
    task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
        @(posedge mclk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge mclk);
        rd   <= 1'b0;
        #1 d = rdata;
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    // Runs one check and records which phases the brakes and torque went through.
    task automatic run_check(input logic [1:0] f, input logic [1:0] dir, input logic [31:0] exp_irq);
        int n;
        n = 0;
        {s_rel, s_mot, s_red, s_pos, s_neg} = 5'h0;
        fault <= f;
        wr_reg(REG_IRQ_CLR, 32'h3f);
        wr_reg(REG_CTRL, (32'(dir) << CTRL_DIR_LO) | 32'h1);
        do begin
            idle(1);
            n++;
            s_rel = s_rel | move;
            s_mot = s_mot | (tcmd === 32'h82 && !mrel && rrel);
            s_red = s_red | (tcmd === 32'h82 && mrel && !rrel);
            s_pos = s_pos | (tcmd === 32'h82 && !neg);
            s_neg = s_neg | (tcmd === 32'h82 && neg);
        end while ((busy === 1'b1 || n < 3) && n < 1000);
        rd_reg(REG_IRQ_STAT, rv);
        cmp(rv & 32'h3e, exp_irq);
    endtask

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic t_reset();
        #1 cmp({25'h0, mval, rval, usable, busy, warn, exc, miss}, 32'h0);
        rd_reg(REG_STATUS, rv);
        cmp(rv, 32'h0);
        rd_reg(8'h40, rv);
        cmp(rv, 32'h0);
    endtask
    task automatic t_special();
        @(posedge mclk);
        spec <= 1'b1;
        idle(4);
        cmp({31'h0, miss}, 32'h1);
        wr_reg(REG_CTRL, 32'h1);
        idle(2);
        cmp({31'h0, busy}, 32'h0);
        rd_reg(REG_IRQ_STAT, rv);
        cmp(rv & 32'h20, 32'h20);
        spec <= 1'b0;
        wr_reg(REG_CTRL, 32'h1);
        idle(2);
        cmp({30'h0, busy, miss}, 32'h0);
    endtask
    task automatic t_torque_gate();
        en <= 1'b1;
        wr_reg(REG_INTERVAL, 32'h2);
        wr_reg(REG_TRAVEL, 32'h8);
        wr_reg(REG_INJECT, 32'h28);
        wr_reg(REG_SAFELOAD, 32'h64);
        wr_reg(REG_NOMLOAD, 32'h81);
        wr_reg(REG_CTRL, 32'h3);
        idle(2);
        cmp({30'h0, busy, exc}, 32'h0);
        wr_reg(REG_NOMLOAD, 32'h82);
    endtask
    task automatic t_faults();
        run_check(2'h1, 2'h1, 32'h2);
        run_check(2'h2, 2'h1, 32'h4);
        run_check(2'h3, 2'h1, 32'h8);
        cmp({29'h0, s_mot, mval, rval}, 32'h4);
    endtask
    task automatic t_pass();
        wr_reg(REG_IRQ_EN, 32'h3f);
        run_check(2'h0, 2'h1, 32'h0);
        cmp({26'h0, s_rel, s_mot, s_red, s_pos, s_neg, 1'b0}, 32'h3c);
        idle(3);
        cmp({27'h0, mval, rval, usable, warn, irq}, 32'h1f);
        rd_reg(REG_REMAIN, rv);
        cmp({31'h0, rv == 32'h2 || rv == 32'h1}, 32'h1);
        wr_reg(REG_IRQ_EN, 32'h0);
        idle(2);
        cmp({31'h0, irq}, 32'h0);
        wr_reg(REG_IRQ_EN, 32'h1);
        idle(2);
        cmp({31'h0, irq}, 32'h1);
        wr_reg(REG_IRQ_CLR, 32'h1);
        idle(2);
        cmp({31'h0, irq}, 32'h0);
    endtask
    task automatic t_dirs();
        run_check(2'h0, 2'h2, 32'h0);
        cmp({30'h0, s_pos, s_neg}, 32'h1);
        run_check(2'h0, 2'h3, 32'h0);
        cmp({29'h0, s_pos, s_neg, warn}, 32'h7);
        @(posedge mclk);
        en <= 1'b0;
        idle(3);
        cmp({30'h0, mval, warn}, 32'h2);
    endtask

    initial begin
        repeat (10) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        t_reset();
        t_special();
        t_torque_gate();
        t_faults();
        t_pass();
        t_dirs();
        results();
    end
endmodule
`default_nettype wire
